/* include/gctl_pkg.sv */
// Constants for the global control and pin configuration block.
// Assumes a 16-bit register port and a single 20 MHz system clock.
package gctl_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h02;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADDR_PIN_FUNC = 8'h0A;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_LATCHED  = 8'h16;
    localparam logic [7:0] ADDR_PIN_READ = 8'h1C;

    // First control register fields
    localparam int unsigned C1_FULL_RST  = 0;
    localparam int unsigned C1_DP_RST    = 1;
    localparam int unsigned C1_CLR_RD    = 2;
    localparam int unsigned C1_PERF_REQ  = 3;
    localparam int unsigned C1_MODE_LO   = 4;
    localparam int unsigned C1_ERR_SEL   = 6;
    localparam int unsigned C1_ERR_SW    = 7;
    localparam logic [15:0] C1_RESET     = 16'h0002;
    localparam logic [15:0] C1_WMASK     = 16'h00FF;

    // Second control register fields
    localparam int unsigned C2_ADAPT_LO  = 1;
    localparam int unsigned C2_IN_SEL    = 8;
    localparam int unsigned C2_OUT_SEL   = 9;
    localparam int unsigned C2_SRC_LO    = 10;
    localparam logic [15:0] C2_RESET     = 16'h0000;
    localparam logic [15:0] C2_WMASK     = 16'h0F0E;

    localparam logic [15:0] PIN_FUNC_RESET = 16'h0000;

    // Latched status bit positions in the readback word
    localparam int unsigned L_DONE  = 0;
    localparam int unsigned L_ONES  = 2;
    localparam int unsigned L_REF8K = 4;

    // Soft reset minimum width, rounded up to whole cycles
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned SOFT_RST_MIN_NS = 100;
    localparam logic [1:0]  SOFT_RST_MIN_CYC =
        2'((SOFT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Divider defaults: adapter ticks per 8 kHz tick, 8 kHz ticks per second
    localparam logic [15:0] ADAPT_DIV_DEFAULT = 16'h15D8;
    localparam logic [13:0] SEC_DIV_DEFAULT   = 14'h1F40;

    typedef enum logic [1:0] {
        FN_INPUT  = 2'b00,
        FN_STATUS = 2'b01,
        FN_LOW    = 2'b10,
        FN_HIGH   = 2'b11
    } pin_func_t;

    typedef enum logic [1:0] {
        SRC_NONE    = 2'b00,
        SRC_ADAPTER = 2'b01,
        SRC_PORT    = 2'b10,
        SRC_UNDEF   = 2'b11
    } ref_src_t;

    typedef enum logic [1:0] {
        PM_SOFT = 2'b00,
        PM_PIN  = 2'b01,
        PM_SEC  = 2'b10,
        PM_SEC2 = 2'b11
    } perf_mode_t;

    // Adapter reference frequency codes: 44.736, 34.368, 51.84, 19.44, 77.76 MHz
    typedef enum logic [2:0] {
        AREF_44M736 = 3'h0,
        AREF_34M368 = 3'h1,
        AREF_51M84  = 3'h2,
        AREF_19M44  = 3'h3,
        AREF_77M76  = 3'h4
    } adapt_ref_t;
endpackage

/* include/ref8k_if.sv */
// Carrier between the register block and the 8 kHz / one-second timer.
// All signals are on the single system clock.
`timescale 1ns/100ps
interface ref8k_if;
    logic [1:0] src;
    logic       pin_sel;
    logic       pin4_level;
    logic       hold;
    logic       ref_tick;
    logic       one_sec;

    modport ctl   (output src, output pin_sel, output pin4_level, output hold,
                   input ref_tick, input one_sec);
    modport timer (input src, input pin_sel, input pin4_level, input hold,
                   output ref_tick, output one_sec);
endinterface

/* src/global_ctrl.sv */
// Global control registers: soft resets, performance update, 8 kHz
// reference and general purpose pin functions.
// Assumes one 20 MHz clock; pins arrive asynchronous, core inputs are same-clock.
//
// Summary of operation
// - Request rising edge copies counters to followers and resets counters.
// - Done status clears when the host lowers the request bit.
// - Clear-policy bit: 0 clears latched bits on write, 1 on read.
// - Data-path reset bit high holds data-path registers at defaults.
// - Data-path reset bit reads 1 after general reset.
// - Full reset bit high defaults all registers except itself.
// - Source field: 00 off, 01 adapter clock, 10 port reference, 11 undefined.
// - Pin input select high takes 8 kHz reference from pin four.
// - One-second reference is derived from the selected 8 kHz reference.
// - Output select high drives 8 kHz reference on pin two.
// - Input select high makes pin four the global 8 kHz input.
// - Internal 8 kHz input is low when pin four not selected.
// - Three-bit field tells rate adapter its reference frequency.
// - Pin field: 00 input, 10 drive low, 11 drive high.
// - Pin two code 01 outputs the chosen port B status.
// - Pin eight field needs mode not 01; pin six needs error select 0.
// - Update mode: 00 software bit, 01 pin eight, 1x one-second counter.
// - Error select high takes error trigger from pin six.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module global_ctrl #(
    parameter logic [15:0] ADAPT_DIV = gctl_pkg::ADAPT_DIV_DEFAULT,
    parameter logic [13:0] SEC_DIV   = gctl_pkg::SEC_DIV_DEFAULT
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // General purpose pins, index 0 is pin one
    input  wire logic [7:0]  gpio_in,
    output logic      [7:0]  gpio_out,
    output logic      [7:0]  gpio_oe,
    // Core side inputs
    input  wire logic        adapter_tick,
    input  wire logic        port_ref_tick,
    input  wire logic        port_a_status,
    input  wire logic        port_b_status,
    input  wire logic        perf_done_in,
    // Core side outputs
    output logic             perf_update_strobe,
    output logic             err_insert_pulse,
    output logic             datapath_reset,
    output logic             full_reset,
    output logic             latched_clear_on_read,
    output logic      [2:0]  adapter_ref_sel,
    output logic             ref8k_in_signal,
    output logic             ref8k_tick,
    output logic             one_second
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [15:0] ctl1_r, ctl1_nxt;
    logic [15:0] ctl2_r, ctl2_nxt;
    logic [15:0] pfunc_r, pfunc_nxt;
    logic [7:0]  pin_s1_r, pin_s2_r, pin_d_r;
    logic        wr_c1, wr_c2, wr_pf, wr_lat, rd_lat, full_on;
    logic [1:0]  mode;
    logic [7:0]  pin_rise;

    ref8k_if rif();

    assign wr_c1    = reg_wr && reg_addr == gctl_pkg::ADDR_CTRL_ONE;
    assign wr_c2    = reg_wr && reg_addr == gctl_pkg::ADDR_CTRL_TWO;
    assign wr_pf    = reg_wr && reg_addr == gctl_pkg::ADDR_PIN_FUNC;
    assign wr_lat   = reg_wr && reg_addr == gctl_pkg::ADDR_LATCHED;
    assign rd_lat   = reg_rd && reg_addr == gctl_pkg::ADDR_LATCHED;
    assign full_on  = ctl1_r[gctl_pkg::C1_FULL_RST];
    assign mode     = ctl1_r[gctl_pkg::C1_MODE_LO +: 2];
    assign pin_rise = pin_s2_r & ~pin_d_r;

    // Two-stage synchroniser on the pins; only stage two is looked at
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            pin_d_r  <= 8'h00;
        end else begin
            pin_s1_r <= gpio_in;
            pin_s2_r <= pin_s1_r;
            pin_d_r  <= pin_s2_r;
        end
    end

    // Control registers; full reset defaults all but its own bit
    always_comb begin
        ctl1_nxt  = wr_c1 ? (reg_wdata & gctl_pkg::C1_WMASK) : ctl1_r;
        ctl2_nxt  = wr_c2 ? (reg_wdata & gctl_pkg::C2_WMASK) : ctl2_r;
        pfunc_nxt = wr_pf ? reg_wdata : pfunc_r;
        if (full_on) begin
            ctl1_nxt = gctl_pkg::C1_RESET;
            ctl1_nxt[gctl_pkg::C1_FULL_RST] = wr_c1 ? reg_wdata[gctl_pkg::C1_FULL_RST] : 1'b1;
            ctl2_nxt  = gctl_pkg::C2_RESET;
            pfunc_nxt = gctl_pkg::PIN_FUNC_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl1_r  <= gctl_pkg::C1_RESET;
            ctl2_r  <= gctl_pkg::C2_RESET;
            pfunc_r <= gctl_pkg::PIN_FUNC_RESET;
        end else begin
            ctl1_r  <= ctl1_nxt;
            ctl2_r  <= ctl2_nxt;
            pfunc_r <= pfunc_nxt;
        end
    end

    // Performance update, error insert and latched status
    logic       req_d_r, req_d_nxt, err_d_r, err_d_nxt;
    logic       done_r, done_nxt;
    logic [2:0] lat_r, lat_nxt, lat_set, lat_clr;
    logic       req_level, perf_trig, err_trig;

    always_comb begin
        req_d_nxt = ctl1_r[gctl_pkg::C1_PERF_REQ];
        err_d_nxt = ctl1_r[gctl_pkg::C1_ERR_SW];
        // Trigger source per update mode, each edge taken once
        case (gctl_pkg::perf_mode_t'(mode))
            gctl_pkg::PM_SOFT: begin
                req_level = ctl1_r[gctl_pkg::C1_PERF_REQ];
                perf_trig = ctl1_r[gctl_pkg::C1_PERF_REQ] & ~req_d_r;
            end
            gctl_pkg::PM_PIN: begin
                req_level = pin_s2_r[7];
                perf_trig = pin_rise[7];
            end
            default: begin
                req_level = 1'b1;
                perf_trig = rif.one_sec;
            end
        endcase
        err_trig = ctl1_r[gctl_pkg::C1_ERR_SEL] ? pin_rise[5]
                 : (ctl1_r[gctl_pkg::C1_ERR_SW] & ~err_d_r);
        // Done drops as soon as the request level goes low
        done_nxt = perf_done_in & req_level;
        lat_set = 3'h0;
        lat_set[0] = done_nxt & ~done_r;
        lat_set[1] = rif.one_sec;
        lat_set[2] = rif.ref_tick & rif.pin_sel;
        // Policy picks read-clear or write-one-to-clear; set beats clear
        if (ctl1_r[gctl_pkg::C1_CLR_RD]) begin
            lat_clr = rd_lat ? 3'h7 : 3'h0;
        end else begin
            lat_clr = wr_lat ? {reg_wdata[gctl_pkg::L_REF8K], reg_wdata[gctl_pkg::L_ONES],
                                reg_wdata[gctl_pkg::L_DONE]} : 3'h0;
        end
        lat_nxt = (lat_r & ~lat_clr) | lat_set;
        if (full_on) begin
            done_nxt = 1'b0;
            lat_nxt  = 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_d_r <= 1'b0;
            err_d_r <= 1'b0;
            done_r  <= 1'b0;
            lat_r   <= 3'h0;
        end else begin
            req_d_r <= req_d_nxt;
            err_d_r <= err_d_nxt;
            done_r  <= done_nxt;
            lat_r   <= lat_nxt;
        end
    end

    // Pin drivers, one slice per pin; overrides turn pins four, six and eight into inputs and drive pin two
    logic [7:0] oe_nxt, out_nxt;
    for (genvar g = 0; g < 8; g++) begin : g_pin
        always_comb begin
            oe_nxt[g]  = 1'b0;
            out_nxt[g] = 1'b0;
            case (gctl_pkg::pin_func_t'(pfunc_r[2*g +: 2]))
                gctl_pkg::FN_LOW:  oe_nxt[g] = 1'b1;
                gctl_pkg::FN_HIGH: begin
                    oe_nxt[g]  = 1'b1;
                    out_nxt[g] = 1'b1;
                end
                gctl_pkg::FN_STATUS: begin
                    // Status code exists only on pins one and two
                    oe_nxt[g]  = (g == 0) || (g == 1);
                    out_nxt[g] = (g == 0) ? port_a_status
                               : (g == 1) ? port_b_status : 1'b0;
                end
                default: oe_nxt[g] = 1'b0;
            endcase
            if ((g == 7 && mode == 2'b01) || (g == 5 && ctl1_r[gctl_pkg::C1_ERR_SEL])
                    || (g == 3 && ctl2_r[gctl_pkg::C2_IN_SEL])) begin
                oe_nxt[g]  = 1'b0;
                out_nxt[g] = 1'b0;
            end
            if (g == 1 && ctl2_r[gctl_pkg::C2_OUT_SEL]) begin
                oe_nxt[g]  = 1'b1;
                out_nxt[g] = rif.ref_tick;
            end
        end
    end

    // Soft reset stretch guards against a too-short bit pulse
    logic [1:0]  rst_cnt_r, rst_cnt_nxt;
    logic [15:0] rdata_nxt;
    always_comb begin
        if (ctl1_r[gctl_pkg::C1_DP_RST] | full_on) begin
            rst_cnt_nxt = gctl_pkg::SOFT_RST_MIN_CYC;
        end else if (rst_cnt_r != 2'h0) begin
            rst_cnt_nxt = rst_cnt_r - 2'h1;
        end else begin
            rst_cnt_nxt = 2'h0;
        end
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                gctl_pkg::ADDR_CTRL_ONE: rdata_nxt = ctl1_r;
                gctl_pkg::ADDR_CTRL_TWO: rdata_nxt = ctl2_r;
                gctl_pkg::ADDR_PIN_FUNC: rdata_nxt = pfunc_r;
                gctl_pkg::ADDR_STATUS:   rdata_nxt = {15'h0000, done_r};
                gctl_pkg::ADDR_LATCHED:  rdata_nxt = {11'h000, lat_r[2], 1'b0, lat_r[1], 1'b0, lat_r[0]};
                gctl_pkg::ADDR_PIN_READ: rdata_nxt = {8'h00, pin_s2_r};
                default:                 rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_cnt_r             <= 2'h0;
            reg_rdata             <= 16'h0000;
            gpio_out              <= 8'h00;
            gpio_oe               <= 8'h00;
            perf_update_strobe    <= 1'b0;
            err_insert_pulse      <= 1'b0;
            datapath_reset        <= 1'b1;
            full_reset            <= 1'b0;
            latched_clear_on_read <= 1'b0;
            adapter_ref_sel       <= 3'h0;
            ref8k_in_signal       <= 1'b0;
            ref8k_tick            <= 1'b0;
            one_second            <= 1'b0;
        end else begin
            rst_cnt_r             <= rst_cnt_nxt;
            reg_rdata             <= rdata_nxt;
            gpio_out              <= out_nxt;
            gpio_oe               <= oe_nxt;
            perf_update_strobe    <= perf_trig & ~full_on;
            err_insert_pulse      <= err_trig & ~full_on;
            datapath_reset        <= ctl1_r[gctl_pkg::C1_DP_RST] | full_on | (rst_cnt_r != 2'h0);
            full_reset            <= full_on;
            latched_clear_on_read <= ctl1_r[gctl_pkg::C1_CLR_RD];
            adapter_ref_sel       <= ctl2_r[gctl_pkg::C2_ADAPT_LO +: 3];
            ref8k_in_signal       <= ctl2_r[gctl_pkg::C2_IN_SEL] & pin_s2_r[3];
            ref8k_tick            <= rif.ref_tick;
            one_second            <= rif.one_sec;
        end
    end

    assign rif.src        = ctl2_r[gctl_pkg::C2_SRC_LO +: 2];
    assign rif.pin_sel    = ctl2_r[gctl_pkg::C2_IN_SEL];
    assign rif.pin4_level = pin_s2_r[3];
    assign rif.hold       = ctl1_r[gctl_pkg::C1_DP_RST] | full_on;

    ref8k_timer #(.ADAPT_DIV(ADAPT_DIV), .SEC_DIV(SEC_DIV)) u_timer (
        .clk          (clk),
        .rst_n        (rst_n),
        .adapter_tick (adapter_tick),
        .port_ref_tick(port_ref_tick),
        .rf           (rif.timer)
    );

    a_perf_edge_once: assert property (
        (mode == 2'b00 && !full_on && $rose(ctl1_r[3])) |=> perf_update_strobe ##1 !perf_update_strobe)
        else $error("software update edge did not give one strobe");
    a_done_clears: assert property (
        (mode == 2'b00 && !ctl1_r[3]) |=> !done_r)
        else $error("done status stayed set with request low");
    a_read_clears: assert property (
        (rd_lat && ctl1_r[2] && lat_set == 3'h0) |=> lat_r == 3'h0)
        else $error("latched bits not cleared on read");
    a_dp_hold: assert property (
        ctl1_r[1] |=> datapath_reset)
        else $error("data-path reset output low while bit set");
    a_full_defaults: assert property (
        full_on |=> (ctl2_r == 16'h0000 && pfunc_r == 16'h0000 && ctl1_r[1]))
        else $error("registers not defaulted under full reset");
    a_pin2_ref_out: assert property (
        ctl2_r[9] |=> (gpio_oe[1] && gpio_out[1] == $past(rif.ref_tick)))
        else $error("pin two not driving the 8 kHz reference");
    a_pin4_low: assert property (
        !ctl2_r[8] |=> !ref8k_in_signal)
        else $error("8 kHz input high while pin four unselected");
    a_pin8_input: assert property (
        mode == 2'b01 |=> !gpio_oe[7])
        else $error("pin eight driven in pin update mode");
    a_err_from_pin: assert property (
        (ctl1_r[6] && pin_rise[5] && !full_on) |=> err_insert_pulse)
        else $error("pin six edge did not insert an error");
endmodule

/* src/ref8k_timer.sv */
// Global 8 kHz reference selection and one-second divider.
// Assumes pin4_level is already synchronised and tick inputs are one-cycle pulses.
`timescale 1ns/100ps
module ref8k_timer #(
    parameter logic [15:0] ADAPT_DIV = gctl_pkg::ADAPT_DIV_DEFAULT,
    parameter logic [13:0] SEC_DIV   = gctl_pkg::SEC_DIV_DEFAULT
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Tick sources
    input  wire logic  adapter_tick,
    input  wire logic  port_ref_tick,
    // Control side
    ref8k_if.timer     rf
);
    logic [15:0] div_r, div_nxt;
    logic [13:0] sec_r, sec_nxt;
    logic        pin_d_r, pin_d_nxt;
    logic        tick_r, tick_nxt;
    logic        one_r, one_nxt;
    logic        src_tick;

    // Source mux, adapter divider and one-second counter
    always_comb begin
        div_nxt   = div_r;
        sec_nxt   = sec_r;
        pin_d_nxt = rf.pin4_level;
        src_tick  = 1'b0;
        one_nxt   = 1'b0;
        if (rf.pin_sel) begin
            src_tick = rf.pin4_level & ~pin_d_r;
        end else begin
            case (gctl_pkg::ref_src_t'(rf.src))
                gctl_pkg::SRC_ADAPTER: begin
                    if (adapter_tick) begin
                        if (div_r == ADAPT_DIV - 16'h0001) begin
                            div_nxt  = 16'h0000;
                            src_tick = 1'b1;
                        end else begin
                            div_nxt = div_r + 16'h0001;
                        end
                    end
                end
                gctl_pkg::SRC_PORT: src_tick = port_ref_tick;
                default:            div_nxt  = 16'h0000; // Divider disabled
            endcase
        end
        // One second counted from the chosen 8 kHz tick
        if (src_tick) begin
            if (sec_r == SEC_DIV - 14'h0001) begin
                sec_nxt = 14'h0000;
                one_nxt = 1'b1;
            end else begin
                sec_nxt = sec_r + 14'h0001;
            end
        end
        tick_nxt = src_tick;
        if (rf.hold) begin
            div_nxt  = 16'h0000;
            sec_nxt  = 14'h0000;
            tick_nxt = 1'b0;
            one_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_r   <= 16'h0000;
            sec_r   <= 14'h0000;
            pin_d_r <= 1'b0;
            tick_r  <= 1'b0;
            one_r   <= 1'b0;
        end else begin
            div_r   <= div_nxt;
            sec_r   <= sec_nxt;
            pin_d_r <= pin_d_nxt;
            tick_r  <= tick_nxt;
            one_r   <= one_nxt;
        end
    end

    assign rf.ref_tick = tick_r;
    assign rf.one_sec  = one_r;

    a_src_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        (!rf.pin_sel && rf.src == 2'b00) |=> !tick_r)
        else $error("8 kHz tick with source disabled");
    a_sec_from_ref: assert property (@(posedge clk) disable iff (!rst_n)
        (!rf.hold && src_tick && sec_r == SEC_DIV - 14'h0001) |=> one_r)
        else $error("one-second pulse missing after last 8 kHz tick");
endmodule

/* verif/core_side_model.sv */
// Stand-in for the data path: tick sources and the port update-done answer.
// Assumes the control block's clock and synchronous active-low reset.
`timescale 1ns/100ps
module core_side_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // From the control block
    input  wire logic perf_update_strobe,
    // To the control block
    output logic      adapter_tick,
    output logic      port_ref_tick,
    output logic      perf_done_in
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [6:0] done_r;
    logic [6:0] done_nxt;

    // Done answers slowly and outlives the request, so status must gate it
    always_comb begin
        cnt_nxt  = cnt_r + 8'h01;
        done_nxt = perf_update_strobe ? 7'h01 : ((done_r != 7'h00 && done_r < 7'h40) ? done_r + 7'h01 : 7'h00);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r  <= 8'h00;
            done_r <= 7'h00;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    // Adapter every other cycle, port reference every eighth
    assign adapter_tick  = cnt_r[0];
    assign port_ref_tick = (cnt_r[2:0] == 3'h0);
    assign perf_done_in  = (done_r > 7'h03);
endmodule

/* verif/test_global_ctrl.sv */
// Self-checking bench for the global control block.
// Assumes the core-side model answers update strobes and makes ticks.
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; \
    if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module test_global_ctrl;
    localparam logic [7:0] A1 = gctl_pkg::ADDR_CTRL_ONE;
    localparam logic [7:0] A2 = gctl_pkg::ADDR_CTRL_TWO;
    localparam logic [7:0] AP = gctl_pkg::ADDR_PIN_FUNC;
    localparam logic [7:0] AS = gctl_pkg::ADDR_STATUS;
    localparam logic [7:0] AL = gctl_pkg::ADDR_LATCHED;
    logic        clk, rst_n, reg_wr, reg_rd, port_b_status, rd_seen, adapter_tick, port_ref_tick, perf_done_in;
    logic        perf_update_strobe, datapath_reset, full_reset, latched_clear_on_read, ref8k_in_signal;
    logic        one_second, err_insert_pulse, ref8k_tick;
    logic [7:0]  reg_addr, gpio_in, gpio_out, gpio_oe;
    logic [15:0] reg_wdata, reg_rdata, d, e;
    logic [2:0]  adapter_ref_sel;
    logic [31:0] seed;
    int          failures, samples_checked, nstb, nsec, nerr, ntick;
    logic [15:0] exp_q[$];

    global_ctrl #(.ADAPT_DIV(16'h0004), .SEC_DIV(14'h0005)) i_dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .adapter_tick(adapter_tick), .port_ref_tick(port_ref_tick), .port_a_status(1'b0),
        .port_b_status(port_b_status), .perf_done_in(perf_done_in), .perf_update_strobe(perf_update_strobe),
        .err_insert_pulse(err_insert_pulse), .datapath_reset(datapath_reset), .full_reset(full_reset),
        .latched_clear_on_read(latched_clear_on_read), .adapter_ref_sel(adapter_ref_sel),
        .ref8k_in_signal(ref8k_in_signal), .ref8k_tick(ref8k_tick), .one_second(one_second));

    core_side_model i_core (.clk(clk), .rst_n(rst_n), .perf_update_strobe(perf_update_strobe),
        .adapter_tick(adapter_tick), .port_ref_tick(port_ref_tick), .perf_done_in(perf_done_in));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Expected data is noted now, compared by the monitor a cycle later
    task automatic rd(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(v);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask

    task automatic perf(input logic p);
        nstb = 0;
        wr(A1, {12'h000, 1'b1, p, 2'b00});
        wt(10);
        rd(AS, 16'h0001);
        wt(30);
        `CHK(nstb, 1)
        wr(A1, {13'h0000, p, 2'b00});
        wt(2);
        rd(AS, 16'h0000);
        `CHK(latched_clear_on_read, p)
        rd(AL, 16'h0001);
        if (!p) wr(AL, 16'h0001);
        rd(AL, 16'h0000);
        wt(40);
    endtask

    task final_report();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_seen <= reg_rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK(reg_rdata, e)
        end
    end

    always @(posedge clk) begin
        if (perf_update_strobe) nstb++;
        if (one_second) nsec++;
        if (err_insert_pulse) nerr++;
        if (ref8k_tick) ntick++;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        {rst_n, reg_wr, reg_rd, port_b_status} = 4'h0;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        gpio_in   = 8'h00;
        seed      = 32'h0CEB;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wt(1);
        `CHK(datapath_reset, 1'b1)
        rd(A1, 16'h0002);
        rd(A2, 16'h0000);
        rd(AP, 16'h0000);
        rd(8'h06, 16'h0000);
        wr(A1, 16'h0000);
        wt(1);
        `CHK(datapath_reset, 1'b1)
        wt(5);
        `CHK(datapath_reset, 1'b0)
        $display("test reset done");
        perf(1'b0);
        perf(1'b1);
        $display("test update done");
        repeat (3) begin
            d = 16'(xs());
            gpio_in <= d[7:0];
            wr(A2, d);
            rd(A2, d & gctl_pkg::C2_WMASK);
            `CHK(adapter_ref_sel, d[3:1])
            wr(AP, d);
            rd(AP, d);
        end
        wr(A2, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            d = {2'b00, 2'(c), 2'b00, 2'(c), 2'b00, 2'(c), 4'h0};
            wr(AP, d);
            wt(2);
            `CHK(gpio_oe & 8'h54, (c > 1) ? 8'h54 : 8'h00)
            `CHK(gpio_out & 8'h54, (c == 3) ? 8'h54 : 8'h00)
        end
        wr(AP, 16'h0004);
        for (int b = 0; b < 2; b++) begin
            port_b_status <= 1'(b);
            wt(4);
            `CHK({gpio_oe[1], gpio_out[1]}, {1'b1, 1'(b)})
        end
        wr(AP, 16'hC000);
        wt(2);
        `CHK(gpio_oe[7], 1'b1)
        wr(A1, 16'h0010);
        wt(2);
        `CHK(gpio_oe[7], 1'b0)
        wr(A1, 16'h0020);
        $display("test pins done");
        gpio_in <= 8'h08;
        wt(4);
        `CHK(ref8k_in_signal, 1'b0)
        wr(A2, 16'h0100);
        wt(4);
        `CHK(ref8k_in_signal, 1'b1)
        for (int s = 0; s < 3; s++) begin
            wr(A2, 16'(s) << 10);
            wt(4);
            nsec = 0;
            ntick = 0;
            nstb = 0;
            wt(200);
            `CHK(nsec > 0, s != 0)
            `CHK(ntick > 20, s != 0)
            `CHK(nstb > 0, s != 0)
        end
        $display("test reference done");
        nerr = 0;
        wr(A1, 16'h0080);
        wt(2);
        `CHK(nerr, 1)
        wr(A1, 16'h0040);
        gpio_in <= 8'h28;
        wt(6);
        `CHK(nerr, 2)
        wr(A2, 16'h0300);
        gpio_in <= 8'h00;
        wt(4);
        `CHK(gpio_oe[1], 1'b1)
        ntick = 0;
        gpio_in <= 8'h08;
        wt(6);
        `CHK(ntick, 1)
        $display("test error and pin reference done");
        wr(A1, 16'h0001);
        wt(2);
        `CHK({full_reset, datapath_reset}, 2'b11)
        rd(A2, 16'h0000);
        rd(A1, 16'h0003);
        wr(A1, 16'h0000);
        rd(A1, 16'h0002);
        wt(4);
        $display("test full reset done");
        final_report();
    end
endmodule
